// ===== qdsc_consts.vh
/*
 * Constants of the quad DAC serial control block: frame layout, command
 * codes, readback pointer selectors and synchroniser reset levels.
 * Assumes it is included by bare name from the design files.
 */
`ifndef QDSC_CONSTS_VH
`define QDSC_CONSTS_VH

// Frame layout.
`define QDSC_FRAME_BITS   6'h18
`define QDSC_HDR_BITS     6'h08
`define QDSC_LONG_HDR     6'h10
`define QDSC_CNT_MAX      6'h3F

// Command codes.
`define QDSC_CMD_WR_SPAN      4'h2
`define QDSC_CMD_WR_CODE      4'h3
`define QDSC_CMD_UPD_N        4'h4
`define QDSC_CMD_UPD_ALL      4'h5
`define QDSC_CMD_WR_SPAN_UPD  4'h6
`define QDSC_CMD_WR_CODE_UPD  4'h7
`define QDSC_CMD_WR_SPAN_ALL  4'h8
`define QDSC_CMD_WR_CODE_ALL  4'h9
`define QDSC_CMD_RD_H_SPAN    4'hA
`define QDSC_CMD_RD_H_CODE    4'hB
`define QDSC_CMD_RD_A_SPAN    4'hC
`define QDSC_CMD_RD_A_CODE    4'hD
`define QDSC_CMD_SLEEP        4'hE
`define QDSC_CMD_NOP          4'hF

// Readback pointer buffer selectors.
`define QDSC_SEL_H_SPAN   2'h0
`define QDSC_SEL_H_CODE   2'h1
`define QDSC_SEL_A_SPAN   2'h2
`define QDSC_SEL_A_CODE   2'h3

// Synchronised pin order {clear_n, load_n, select_n, data, sclk} and idle levels.
`define QDSC_PIN_IDLE     5'h1C

`endif

// ===== qdsc_sync.v
/*
 * Two-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level relative to the core clock, so bits need
 * not stay coherent with each other.
 */
`timescale 1ns/1ps
module qdsc_sync #(
  parameter          WIDTH   = 5,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             core_clk_i,
  input  wire             srst_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  // The first stage feeds only the second, so metastability never spreads.
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      meta   <= RST_VAL;
      stable <= RST_VAL;
    end
    else
    begin
      meta   <= async_i;
      stable <= meta;
    end
  end

  assign sync_o = stable;

endmodule // qdsc_sync

// ===== qdsc_serial_ctrl.v
/*
 * Serial control logic of a quad voltage-output DAC: frame capture, command
 * execution, holding and active buffers, rolling readback, load, clear and
 * reset flag. Assumes all pins are asynchronous to core_clk_i and that the
 * serial clock runs well below a quarter of the core clock rate.
 */
`timescale 1ns/1ps
`include "qdsc_consts.vh"
module qdsc_serial_ctrl #(
  parameter CHANNELS = 4
) (
  input  wire                     core_clk_i,
  input  wire                     srst_i,
  input  wire                     sclk_i,
  input  wire                     select_load_n_i,
  input  wire                     serial_in_i,
  input  wire                     async_load_n_i,
  input  wire                     async_clear_n_i,
  output reg                      readback_out_o,
  output reg                      readback_oe_n_o,
  output reg                      reset_flag_n_o,
  output wire [CHANNELS*16-1:0]   active_code_o,
  output wire [CHANNELS*4-1:0]    active_span_o,
  output wire [CHANNELS-1:0]      sleep_o
);

  wire [4:0]  pins_s;
  wire        sclk_s;
  wire        serial_in_s;
  wire        select_n_s;
  wire        load_n_s;
  wire        clear_n_s;

  reg         sclk_prev;
  reg         select_prev;
  reg  [31:0] shift_reg;
  reg  [5:0]  bit_cnt;
  reg         long_frame;
  reg  [15:0] rb_shift;
  reg         rb_active;
  reg  [1:0]  ptr_sel;
  reg  [1:0]  ptr_ch;
  reg  [CHANNELS-1:0] upd_mask;
  reg  [CHANNELS-1:0] sleep_req;

  reg  [15:0] hold_code [0:CHANNELS-1];
  reg  [3:0]  hold_span [0:CHANNELS-1];
  reg  [15:0] act_code  [0:CHANNELS-1];
  reg  [3:0]  act_span  [0:CHANNELS-1];
  reg  [CHANNELS-1:0] sleep_st;

  wire        sclk_rise;
  wire        sclk_fall;
  wire        frame_end;
  wire [31:0] next_shift;
  wire [7:0]  new_byte;
  wire [3:0]  ex_cmd;
  wire [1:0]  ex_ch;
  wire [15:0] ex_data;
  integer     i;

  // Buffer selector that a command leaves as the pointer for the next frame.
  function [1:0] ptr_of_cmd;
    input [3:0] cmd;
    begin
      case (cmd)
        `QDSC_CMD_WR_SPAN,
        `QDSC_CMD_RD_H_SPAN:   ptr_of_cmd = `QDSC_SEL_H_SPAN;
        `QDSC_CMD_WR_CODE,
        `QDSC_CMD_RD_H_CODE:   ptr_of_cmd = `QDSC_SEL_H_CODE;
        `QDSC_CMD_UPD_N,
        `QDSC_CMD_WR_SPAN_UPD,
        `QDSC_CMD_WR_SPAN_ALL,
        `QDSC_CMD_RD_A_SPAN,
        `QDSC_CMD_SLEEP:       ptr_of_cmd = `QDSC_SEL_A_SPAN;
        default:               ptr_of_cmd = `QDSC_SEL_A_CODE;
      endcase
    end
  endfunction

  // True for read commands, which answer in their own frame.
  function is_read;
    input [3:0] cmd;
    begin
      is_read = (cmd >= `QDSC_CMD_RD_H_SPAN) && (cmd <= `QDSC_CMD_RD_A_CODE);
    end
  endfunction

  // Word presented on readback; span words carry the sleep bit above the span.
  function [15:0] rb_word;
    input [1:0] sel;
    input [1:0] ch;
    begin
      case (sel)
        `QDSC_SEL_H_SPAN: rb_word = {11'h000, sleep_st[ch], hold_span[ch]};
        `QDSC_SEL_H_CODE: rb_word = hold_code[ch];
        `QDSC_SEL_A_SPAN: rb_word = {11'h000, sleep_st[ch], act_span[ch]};
        default:          rb_word = act_code[ch];
      endcase
    end
  endfunction

  // Every pin, the serial clock included, passes two flops first.
  qdsc_sync #(
    .WIDTH   (5),
    .RST_VAL (`QDSC_PIN_IDLE)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .async_i    ({async_clear_n_i, async_load_n_i, select_load_n_i, serial_in_i, sclk_i}),
    .sync_o     (pins_s)
  );

  assign sclk_s      = pins_s[0];
  assign serial_in_s = pins_s[1];
  assign select_n_s  = pins_s[2];
  assign load_n_s    = pins_s[3];
  assign clear_n_s   = pins_s[4];

  // Edges are found on the synchronised copies only.
  assign sclk_rise  = sclk_s & ~sclk_prev & ~select_n_s;
  assign sclk_fall  = ~sclk_s & sclk_prev & ~select_n_s;
  assign frame_end  = select_n_s & ~select_prev;
  assign next_shift = {shift_reg[30:0], serial_in_s};
  assign new_byte   = next_shift[7:0];

  // The last 24 captured bits hold command, address and data.
  assign ex_cmd  = shift_reg[23:20];
  assign ex_ch   = shift_reg[18:17];
  assign ex_data = shift_reg[15:0];

  // Frame capture, readback shifting and pointer tracking.
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      sclk_prev       <= 1'b0;
      select_prev     <= 1'b1;
      shift_reg       <= 32'h0000_0000;
      bit_cnt         <= 6'h00;
      long_frame      <= 1'b0;
      rb_shift        <= 16'h0000;
      rb_active       <= 1'b0;
      readback_out_o  <= 1'b0;
      readback_oe_n_o <= 1'b1;
      ptr_sel         <= `QDSC_SEL_A_CODE;
      ptr_ch          <= 2'h0;
    end
    else
    begin
      sclk_prev       <= sclk_s;
      select_prev     <= select_n_s;
      readback_oe_n_o <= select_n_s;
      if (select_n_s)
      begin
        bit_cnt        <= 6'h00;
        long_frame     <= 1'b0;
        rb_active      <= 1'b0;
        readback_out_o <= 1'b0;
      end
      else if (sclk_rise)
      begin
        shift_reg <= next_shift;
        if (bit_cnt != `QDSC_CNT_MAX)
          bit_cnt <= bit_cnt + 6'h01;
        // A zero first byte cannot be a command, so it marks the long frame.
        if (bit_cnt == `QDSC_HDR_BITS - 6'h01 && new_byte == 8'h00)
          long_frame <= 1'b1;
        else if ((bit_cnt == `QDSC_HDR_BITS - 6'h01 && !long_frame) ||
                 (bit_cnt == `QDSC_LONG_HDR - 6'h01 && long_frame))
        begin
          // Final address bit just arrived: load the readback word.
          rb_active <= 1'b1;
          if (is_read(new_byte[7:4]))
            rb_shift <= rb_word(ptr_of_cmd(new_byte[7:4]), new_byte[2:1]);
          else
            rb_shift <= rb_word(ptr_sel, ptr_ch);
        end
      end
      else if (sclk_fall && rb_active)
      begin
        readback_out_o <= rb_shift[15];
        rb_shift       <= {rb_shift[14:0], 1'b0};
      end
      if (frame_end && bit_cnt >= `QDSC_FRAME_BITS)
      begin
        ptr_sel <= ptr_of_cmd(ex_cmd);
        ptr_ch  <= ex_ch;
      end
    end
  end

  // Command execution at frame end; updates apply one cycle later so that a
  // write-and-update copies the freshly written holding value.
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      upd_mask  <= {CHANNELS{1'b0}};
      sleep_req <= {CHANNELS{1'b0}};
      for (i = 0; i < CHANNELS; i = i + 1)
      begin
        hold_code[i] <= 16'h0000;
        hold_span[i] <= 4'h0;
      end
    end
    else
    begin
      upd_mask  <= {CHANNELS{1'b0}};
      sleep_req <= {CHANNELS{1'b0}};
      if (frame_end && bit_cnt >= `QDSC_FRAME_BITS)
      begin
        case (ex_cmd)
          `QDSC_CMD_WR_SPAN,
          `QDSC_CMD_WR_SPAN_UPD,
          `QDSC_CMD_WR_SPAN_ALL: hold_span[ex_ch] <= ex_data[3:0];
          `QDSC_CMD_WR_CODE,
          `QDSC_CMD_WR_CODE_UPD,
          `QDSC_CMD_WR_CODE_ALL: hold_code[ex_ch] <= ex_data;
          default: ;
        endcase
        case (ex_cmd)
          `QDSC_CMD_UPD_N,
          `QDSC_CMD_WR_SPAN_UPD,
          `QDSC_CMD_WR_CODE_UPD: upd_mask[ex_ch] <= 1'b1;
          `QDSC_CMD_UPD_ALL,
          `QDSC_CMD_WR_SPAN_ALL,
          `QDSC_CMD_WR_CODE_ALL: upd_mask <= {CHANNELS{1'b1}};
          `QDSC_CMD_SLEEP:       sleep_req[ex_ch] <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // Per-channel active buffers; clear overrides any copy.
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : g_chan
      always @(posedge core_clk_i)
      begin
        if (srst_i || !clear_n_s)
        begin
          act_code[g] <= 16'h0000;
          act_span[g] <= 4'h0;
        end
        else if (!load_n_s || upd_mask[g])
        begin
          act_code[g] <= hold_code[g];
          act_span[g] <= hold_span[g];
        end
      end

      // Any update, serial or by the load pin, wakes the channel.
      always @(posedge core_clk_i)
      begin
        if (srst_i)
          sleep_st[g] <= 1'b0;
        else if (!load_n_s || upd_mask[g])
          sleep_st[g] <= 1'b0;
        else if (sleep_req[g])
          sleep_st[g] <= 1'b1;
      end

      assign active_code_o[g*16 +: 16] = act_code[g];
      assign active_span_o[g*4 +: 4]   = act_span[g];
      assign sleep_o[g]                = sleep_st[g];
    end
  endgenerate

  // Reset flag: clear holds it low, so a clear asserted with a load keeps it low.
  always @(posedge core_clk_i)
  begin
    if (srst_i || !clear_n_s)
      reset_flag_n_o <= 1'b0;
    else if ((|upd_mask) || !load_n_s)
      reset_flag_n_o <= 1'b1;
  end

endmodule // qdsc_serial_ctrl

// ===== qdsc_serial_ctrl_props.sv
/* Checker of the serial link, load, clear and flag outputs.
   Assumes it is bound to qdsc_serial_ctrl and the bench keeps select high around load and clear. */
`timescale 1ns/1ps
module qdsc_serial_ctrl_props #(
  parameter CHANNELS = 4
) (
  input wire                   core_clk_i,
  input wire                   srst_i,
  input wire                   sclk_i,
  input wire                   select_load_n_i,
  input wire                   serial_in_i,
  input wire                   async_load_n_i,
  input wire                   async_clear_n_i,
  input wire                   readback_out_o,
  input wire                   readback_oe_n_o,
  input wire                   reset_flag_n_o,
  input wire [CHANNELS*16-1:0] active_code_o,
  input wire [CHANNELS*4-1:0]  active_span_o,
  input wire [CHANNELS-1:0]    sleep_o
);
  // Pins pass two flops, so each relation allows the synchroniser delay.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  chk_oe_drive: assert property ((!select_load_n_i)[*4] |-> !readback_oe_n_o)
    else $error("readback not driven in frame");
  chk_oe_release: assert property (select_load_n_i[*4] |-> readback_oe_n_o && !readback_out_o)
    else $error("readback driven outside frame");
  chk_out_on_fall: assert property ($changed(readback_out_o) && !readback_oe_n_o && !select_load_n_i
    |-> !$past(sclk_i, 2)) else $error("readback moved without clock fall");
  chk_clear_zero: assert property ((!async_clear_n_i)[*5] |-> active_code_o == '0 && active_span_o == '0)
    else $error("clear left active data");
  chk_clear_flag: assert property ((!async_clear_n_i)[*5] |-> !reset_flag_n_o)
    else $error("clear left flag high");
  chk_load_flag: assert property ((async_clear_n_i && !async_load_n_i)[*5] |-> reset_flag_n_o)
    else $error("load did not release flag");
  chk_flag_serial: assert property ($rose(reset_flag_n_o) && $past(async_load_n_i, 3)
    && $past(async_load_n_i, 4) |-> $past(select_load_n_i, 4)) else $error("flag released inside frame");
  chk_active_hold: assert property ($changed(active_code_o) || $changed(active_span_o)
    |-> select_load_n_i) else $error("active data moved during frame");
  // Main scenarios reached.
  cov_flag: cover property ($rose(reset_flag_n_o));
  cov_clear: cover property ((!async_clear_n_i)[*5]);
  cov_rdbk: cover property ($rose(readback_out_o) && !readback_oe_n_o);
  cov_sleep: cover property ($rose(sleep_o[3]));
endmodule // qdsc_serial_ctrl_props
bind qdsc_serial_ctrl qdsc_serial_ctrl_props #(.CHANNELS(CHANNELS)) i_props (
  .core_clk_i      (core_clk_i),
  .srst_i          (srst_i),
  .sclk_i          (sclk_i),
  .select_load_n_i (select_load_n_i),
  .serial_in_i     (serial_in_i),
  .async_load_n_i  (async_load_n_i),
  .async_clear_n_i (async_clear_n_i),
  .readback_out_o  (readback_out_o),
  .readback_oe_n_o (readback_oe_n_o),
  .reset_flag_n_o  (reset_flag_n_o),
  .active_code_o   (active_code_o),
  .active_span_o   (active_span_o),
  .sleep_o         (sleep_o)
);

// ===== qdsc_host_model.sv
/* Serial master model that frames commands on the link.
   Assumes the bench resolves the three-state readback line. */
`timescale 1ns/1ps
module qdsc_host_model (
  input  wire core_clk_i,
  input  wire readback_i,
  output reg  sclk_o,
  output reg  select_load_n_o,
  output reg  serial_in_o
);
  integer half = 4;
  // Idle link: clock still and low, select high.
  initial
  begin
    sclk_o = 1'b0;
    select_load_n_o = 1'b1;
    serial_in_o = 1'b0;
  end
  // Steps just past a core edge, like the bench.
  task tick(input integer n);
  begin
    repeat (n) @(posedge core_clk_i);
    #1;
  end
  endtask
  // Frame of n bits, MSB first; readback is taken late in the high
  // phase so the synchroniser delay never races the sample.
  task frame(input integer n, input [31:0] w, output [31:0] rb);
    integer i;
  begin
    rb = 32'h0000_0000;
    select_load_n_o = 1'b0;
    tick(half);
    for (i = n - 1; i >= 0; i = i - 1)
    begin
      serial_in_o = w[i];
      tick(half);
      sclk_o = 1'b1;
      tick(half - 1);
      rb = {rb[30:0], readback_i};
      tick(1);
      if (i > 0) sclk_o = 1'b0;
    end
    select_load_n_o = 1'b1;
    serial_in_o = ~serial_in_o; // Released data line shows no stale bit.
    tick(half);
    sclk_o = 1'b0;
    tick(half);
  end
  endtask
endmodule // qdsc_host_model

// ===== qdsc_serial_ctrl_bench.sv
/* Self-checking bench of the quad DAC serial control block.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/1ps
`include "qdsc_consts.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module qdsc_serial_ctrl_bench;
  reg         core_clk_i = 1'b0;
  reg         srst_i = 1'b1;
  reg         async_load_n_i = 1'b1;
  reg         async_clear_n_i = 1'b1;
  wire        sclk_i;
  wire        select_load_n_i;
  wire        serial_in_i;
  wire        readback_out_o;
  wire        readback_oe_n_o;
  wire        reset_flag_n_o;
  wire [63:0] active_code_o;
  wire [15:0] active_span_o;
  wire [3:0]  sleep_o;
  wire        rb_line = readback_oe_n_o ? 1'bz : readback_out_o;
  integer     err_total = 0;
  integer     samples_checked = 0;
  reg  [31:0] rb;
  qdsc_serial_ctrl i_dut (
    .core_clk_i      (core_clk_i),
    .srst_i          (srst_i),
    .sclk_i          (sclk_i),
    .select_load_n_i (select_load_n_i),
    .serial_in_i     (serial_in_i),
    .async_load_n_i  (async_load_n_i),
    .async_clear_n_i (async_clear_n_i),
    .readback_out_o  (readback_out_o),
    .readback_oe_n_o (readback_oe_n_o),
    .reset_flag_n_o  (reset_flag_n_o),
    .active_code_o   (active_code_o),
    .active_span_o   (active_span_o),
    .sleep_o         (sleep_o)
  );
  qdsc_host_model i_host (
    .core_clk_i      (core_clk_i),
    .readback_i      (rb_line),
    .sclk_o          (sclk_i),
    .select_load_n_o (select_load_n_i),
    .serial_in_o     (serial_in_i)
  );
  // Core clock of 40 MHz.
  initial
  begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // Helpers: wait cycles, run one frame and let execution settle.
  task wc(input integer n);
  begin
    repeat (n) @(posedge core_clk_i);
    #1;
  end
  endtask
  task xf(input integer n, input [31:0] w);
  begin
    i_host.frame(n, w, rb);
    wc(4);
  end
  endtask
  task t_reset;
  begin
    `CHK("flag", 1'b0, reset_flag_n_o)
    `CHK("oe_n", 1'b1, readback_oe_n_o)
    $display("test reset done");
  end
  endtask
  task t_write;
  begin
    xf(24, {`QDSC_CMD_WR_CODE_UPD, 4'h2, 16'hA5C3});
    `CHK("head", 8'h00, rb[23:16])
    `CHK("code b", 16'hA5C3, active_code_o[31:16])
    `CHK("flag", 1'b1, reset_flag_n_o)
    xf(32, {8'h00, `QDSC_CMD_NOP, 4'h2, 16'h0000});
    `CHK("long head", 16'h0000, rb[31:16])
    `CHK("rolling", 16'hA5C3, rb[15:0])
    $display("test write done");
  end
  endtask
  task t_hold;
  begin
    xf(24, {`QDSC_CMD_WR_CODE, 4'h0, 16'h1234});
    `CHK("code a", 16'h0000, active_code_o[15:0])
    xf(24, {`QDSC_CMD_RD_H_CODE, 4'h0, 16'h0000});
    `CHK("read b1", 16'h1234, rb[15:0])
    xf(20, {`QDSC_CMD_UPD_ALL, 4'h0, 12'h000});
    `CHK("short", 16'h0000, active_code_o[15:0])
    async_load_n_i = 1'b0;
    wc(6);
    async_load_n_i = 1'b1;
    wc(4);
    `CHK("load", 32'hA5C3_1234, active_code_o[31:0])
    $display("test hold done");
  end
  endtask
  task t_clear;
  begin
    xf(24, {`QDSC_CMD_WR_SPAN_UPD, 4'h6, 16'h0003});
    `CHK("span d", 4'h3, active_span_o[15:12])
    async_clear_n_i = 1'b0;
    wc(6);
    async_clear_n_i = 1'b1;
    wc(4);
    `CHK("cleared", 80'h0, {active_code_o, active_span_o})
    `CHK("flag", 1'b0, reset_flag_n_o)
    xf(24, {`QDSC_CMD_UPD_ALL, 4'h0, 16'h0000});
    `CHK("reload", 16'h1234, active_code_o[15:0])
    `CHK("flag", 1'b1, reset_flag_n_o)
    $display("test clear done");
  end
  endtask
  // Sleep, the remaining write, update and read commands, then a second reset.
  task t_sleep;
  begin
    xf(24, {`QDSC_CMD_SLEEP, 4'h6, 16'h0000});
    `CHK("sleep d", 4'h8, sleep_o)
    xf(24, {`QDSC_CMD_RD_A_SPAN, 4'h6, 16'h0000});
    `CHK("read b2 span", 16'h0013, rb[15:0])
    xf(24, {`QDSC_CMD_WR_SPAN, 4'h6, 16'h0005});
    `CHK("span held", 4'h3, active_span_o[15:12])
    xf(24, {`QDSC_CMD_UPD_N, 4'h6, 16'h0000});
    `CHK("roll b1 span", 16'h0015, rb[15:0])
    `CHK("span upd", 4'h5, active_span_o[15:12])
    `CHK("wake", 4'h0, sleep_o)
    xf(24, {`QDSC_CMD_WR_CODE_ALL, 4'h4, 16'h0F0F});
    `CHK("code c", 16'h0F0F, active_code_o[47:32])
    xf(24, {`QDSC_CMD_RD_H_SPAN, 4'h6, 16'h0000});
    `CHK("read b1 span", 16'h0005, rb[15:0])
    xf(24, {`QDSC_CMD_RD_A_CODE, 4'h4, 16'h0000});
    `CHK("read b2 code", 16'h0F0F, rb[15:0])
    xf(24, {`QDSC_CMD_WR_SPAN_ALL, 4'h0, 16'h0001});
    `CHK("span all", 16'h5001, active_span_o)
    srst_i = 1'b1;
    wc(4);
    srst_i = 1'b0;
    wc(3);
    `CHK("flag por", 1'b0, reset_flag_n_o)
    `CHK("oe_n por", 1'b1, readback_oe_n_o)
    $display("test sleep done");
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // Main sequence after eight reset cycles.
  initial
  begin
    wc(8);
    srst_i = 1'b0;
    wc(3);
    t_reset;
    t_write;
    t_hold;
    t_clear;
    t_sleep;
    print_verdict;
  end
  // Fifteen frames need about 80 us; five times that means a hang.
  initial
  begin
    #400_000;
    err_total = err_total + 1;
    print_verdict;
  end
endmodule // qdsc_serial_ctrl_bench
